/* File: eeprom_stream_pkg.sv */
// constants, states and carrier types shared by the streamer files
// assumes a 100 MHz system clock and an active-low power-up reset
package eeprom_stream_pkg;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int MEM_DEPTH = 128;
	localparam int FIFO_DEPTH = 16;
	localparam int N_PINS = 3;
	// positions of the raw pins in the synchroniser vector
	localparam int PIN_TCLK = 0;
	localparam int PIN_SCL = 1;
	localparam int PIN_SDA = 2;
	// nine released edges, then the tenth carries the first bit
	localparam logic [3:0] SYNC_EDGES = 4'h9;
	// eight data slots, slot index 8 is the empty ninth slot
	localparam logic [3:0] NULL_SLOT = 4'h8;
	localparam int CLK_PERIOD_NS = 10;
	localparam int HOLD_NS = 300;
	localparam logic [4:0] HOLD_CYC =
		5'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int SPIKE_NS = 50;
	localparam logic [2:0] SPIKE_CYC =
		3'((SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// first streamed location after power-up; hosts must not rely on it
	localparam logic [ADDR_W-1:0] START_ADDR = 7'h00;

	typedef enum logic [1:0] {
		mode_sync,
		mode_stream,
		mode_hold,
		mode_bidir
	} mode_t;

	// write port handed over by the two-wire protocol logic
	typedef struct packed {
		logic en;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} mem_wr_t;
endpackage

/* File: byte_store.sv */
// the streamed byte array: one write port, one registered read port
// assumes writes come from the protocol logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module byte_store #(
	parameter int AW = 7,
	parameter int DW = 8
) (
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [DW-1:0] wr_data,
	input wire logic rd_en,
	input wire logic [AW-1:0] rd_addr,
	output logic [DW-1:0] rd_data
);
	logic [DW-1:0] mem [0:(1<<AW)-1];
	logic [DW-1:0] rd_data_reg;

	// no reset on the array: contents are nonvolatile by intent
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		if (rd_en) begin
			rd_data_reg <= mem[rd_addr]; // old data on same-address write
		end
	end

	assign rd_data = rd_data_reg;
endmodule
`default_nettype wire

/* File: stream_fifo.sv */
// small first-in first-out buffer with valid/ready on both sides
// assumes both sides run on one clock; depth is a power of two
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] buf_mem [0:DEPTH-1];
	logic [PW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
	logic [PW:0] cnt_reg, cnt_next;
	logic push, pop;

	// full and empty come from the fill count, never guessed
	always_comb begin
		in_ready = (cnt_reg != (PW+1)'(DEPTH));
		out_valid = (cnt_reg != '0);
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		wr_ptr_next = push ? PW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
		rd_ptr_next = pop ? PW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
		cnt_next = cnt_reg;
		if (push && !pop) begin
			cnt_next = (PW+1)'(cnt_reg + 1'b1);
		end else if (pop && !push) begin
			cnt_next = (PW+1)'(cnt_reg - 1'b1);
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			cnt_reg <= cnt_next;
		end
	end

	// storage holds no control state, so it needs no reset
	always_ff @(posedge clk) begin
		if (push) begin
			buf_mem[wr_ptr_reg] <= in_data;
		end
	end

	assign out_data = buf_mem[rd_ptr_reg];
endmodule
`default_nettype wire

/* File: eeprom_streamer.sv */
// transmit-only streaming path and mode switch of a serial eeprom
// assumes pins arrive asynchronous to clk and the two-wire protocol
// logic sits beside this block, taking sda once bidir_mode is high
`timescale 1ns/1ps
`default_nettype none
module eeprom_streamer (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic transmit_only_clock,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire eeprom_stream_pkg::mem_wr_t mem_wr,
	output logic sda_out,
	output logic sda_oe,
	output logic sda_level,
	output logic scl_level,
	output logic bidir_mode,
	output logic write_permit
);
	localparam int AW = eeprom_stream_pkg::ADDR_W;
	localparam int DW = eeprom_stream_pkg::DATA_W;
	localparam int NP = eeprom_stream_pkg::N_PINS;

	// rising edge of a synchronised level against its previous sample
	function automatic logic rose(input logic prev, input logic cur);
		rose = cur && !prev;
	endfunction

	logic [NP-1:0] pins_raw;
	logic [NP-1:0] sync1_reg, sync2_reg;
	logic tclk_s, scl_s, sda_s;

	eeprom_stream_pkg::mode_t mode_reg, mode_next;
	logic [3:0] sync_cnt_reg, sync_cnt_next;
	logic [3:0] slot_reg, slot_next;
	logic [DW-1:0] shift_reg, shift_next;
	logic [4:0] hold_cnt_reg, hold_cnt_next;
	logic [2:0] spike_cnt_reg, spike_cnt_next;
	logic armed_reg, armed_next;
	logic tclk_prev_reg, tclk_prev_next;
	logic sda_out_reg, sda_out_next;
	logic sda_oe_reg, sda_oe_next;
	logic bidir_reg, bidir_next;
	logic permit_reg, permit_next;
	logic sda_lvl_reg, sda_lvl_next;
	logic scl_lvl_reg, scl_lvl_next;
	logic [AW-1:0] addr_reg, addr_next;
	logic pend_reg, pend_next;

	logic tclk_rise, scl_fall_ok, streaming;
	logic rd_en, fifo_in_ready, fifo_out_valid, pop;
	logic [DW-1:0] rd_data, fifo_out_data;

	assign pins_raw[eeprom_stream_pkg::PIN_TCLK] = transmit_only_clock;
	assign pins_raw[eeprom_stream_pkg::PIN_SCL] = scl_in;
	assign pins_raw[eeprom_stream_pkg::PIN_SDA] = sda_in;

	// two-flop synchronisers; only the second stage feeds logic
	genvar gi;
	generate
		for (gi = 0; gi < NP; gi++) begin : g_sync
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					sync1_reg[gi] <= 1'b0;
					sync2_reg[gi] <= 1'b0;
				end else begin
					sync1_reg[gi] <= pins_raw[gi];
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end
		end
	endgenerate

	assign tclk_s = sync2_reg[eeprom_stream_pkg::PIN_TCLK];
	assign scl_s = sync2_reg[eeprom_stream_pkg::PIN_SCL];
	assign sda_s = sync2_reg[eeprom_stream_pkg::PIN_SDA];
	assign tclk_rise = rose(tclk_prev_reg, tclk_s);
	assign streaming = (mode_reg == eeprom_stream_pkg::mode_sync) ||
		(mode_reg == eeprom_stream_pkg::mode_stream);

	// scl fall qualifier: scl must have been seen high, then stay low
	// longer than the spike window, so short glitches never switch mode
	always_comb begin
		armed_next = armed_reg;
		spike_cnt_next = spike_cnt_reg;
		scl_fall_ok = 1'b0;
		if (scl_s) begin
			armed_next = 1'b1;
			spike_cnt_next = 3'h0;
		end else if (armed_reg) begin
			spike_cnt_next = 3'(spike_cnt_reg + 3'h1);
			if (spike_cnt_reg == 3'(eeprom_stream_pkg::SPIKE_CYC - 3'h1)) begin
				scl_fall_ok = 1'b1;
				armed_next = 1'b0;
				spike_cnt_next = 3'h0;
			end
		end
	end

	// prefetch: one read in flight at most, so room seen at issue
	// time is still there when the byte lands in the buffer
	always_comb begin
		rd_en = streaming && !pend_reg && fifo_in_ready;
		pend_next = rd_en;
		addr_next = rd_en ? AW'(addr_reg + 7'h01) : addr_reg;
	end

	// mode and bit-slot sequencer, paced by transmit clock rises
	always_comb begin
		mode_next = mode_reg;
		sync_cnt_next = sync_cnt_reg;
		slot_next = slot_reg;
		shift_next = shift_reg;
		hold_cnt_next = hold_cnt_reg;
		sda_out_next = sda_out_reg;
		sda_oe_next = sda_oe_reg;
		bidir_next = bidir_reg;
		permit_next = 1'b0;
		pop = 1'b0;
		unique case (mode_reg)
			eeprom_stream_pkg::mode_sync: begin
				sda_oe_next = 1'b0;
				if (scl_fall_ok) begin
					mode_next = eeprom_stream_pkg::mode_hold;
					hold_cnt_next = 5'h00;
				end else if (tclk_rise) begin
					sync_cnt_next = 4'(sync_cnt_reg + 4'h1);
					if (sync_cnt_next == eeprom_stream_pkg::SYNC_EDGES) begin
						mode_next = eeprom_stream_pkg::mode_stream;
						slot_next = 4'h0;
					end
				end
			end
			eeprom_stream_pkg::mode_stream: begin
				if (scl_fall_ok) begin
					// freeze the line; no further bits go out
					mode_next = eeprom_stream_pkg::mode_hold;
					hold_cnt_next = 5'h00;
				end else if (tclk_rise) begin
					if (slot_reg == 4'h0) begin
						// an empty buffer leaves the line released and retries
						if (fifo_out_valid) begin
							pop = 1'b1;
							sda_out_next = fifo_out_data[DW-1];
							shift_next = {fifo_out_data[DW-2:0], 1'b0};
							sda_oe_next = 1'b1;
							slot_next = 4'h1;
						end else begin
							sda_oe_next = 1'b0;
						end
					end else if (slot_reg == eeprom_stream_pkg::NULL_SLOT) begin
						sda_oe_next = 1'b0;
						slot_next = 4'h0;
					end else begin
						sda_out_next = shift_reg[DW-1];
						shift_next = {shift_reg[DW-2:0], 1'b0};
						slot_next = 4'(slot_reg + 4'h1);
					end
				end
			end
			eeprom_stream_pkg::mode_hold: begin
				// keep any driven bit past the scl fall before letting go
				hold_cnt_next = 5'(hold_cnt_reg + 5'h01);
				if (hold_cnt_next == eeprom_stream_pkg::HOLD_CYC) begin
					sda_oe_next = 1'b0;
					bidir_next = 1'b1;
					mode_next = eeprom_stream_pkg::mode_bidir;
				end
			end
			eeprom_stream_pkg::mode_bidir: begin
				// no way out but reset: power removal
				sda_oe_next = 1'b0;
				bidir_next = 1'b1;
				permit_next = tclk_s;
			end
		endcase
	end

	// plain samples of the shared pins for the protocol logic
	always_comb begin
		tclk_prev_next = tclk_s;
		sda_lvl_next = sda_s;
		scl_lvl_next = scl_s;
	end

	// power-up reset lands every mode flop in streaming sync
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_reg <= eeprom_stream_pkg::mode_sync;
			sync_cnt_reg <= 4'h0;
			slot_reg <= 4'h0;
			shift_reg <= 8'h00;
			hold_cnt_reg <= 5'h00;
			spike_cnt_reg <= 3'h0;
			armed_reg <= 1'b0;
			tclk_prev_reg <= 1'b0;
			sda_out_reg <= 1'b1;
			sda_oe_reg <= 1'b0;
			bidir_reg <= 1'b0;
			permit_reg <= 1'b0;
			sda_lvl_reg <= 1'b0;
			scl_lvl_reg <= 1'b0;
			addr_reg <= eeprom_stream_pkg::START_ADDR;
			pend_reg <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			sync_cnt_reg <= sync_cnt_next;
			slot_reg <= slot_next;
			shift_reg <= shift_next;
			hold_cnt_reg <= hold_cnt_next;
			spike_cnt_reg <= spike_cnt_next;
			armed_reg <= armed_next;
			tclk_prev_reg <= tclk_prev_next;
			sda_out_reg <= sda_out_next;
			sda_oe_reg <= sda_oe_next;
			bidir_reg <= bidir_next;
			permit_reg <= permit_next;
			sda_lvl_reg <= sda_lvl_next;
			scl_lvl_reg <= scl_lvl_next;
			addr_reg <= addr_next;
			pend_reg <= pend_next;
		end
	end

	// 128 locations: the 7-bit address wraps on its own
	byte_store #(
		.AW(AW),
		.DW(DW)
	) u_store (
		.clk(clk),
		.wr_en(mem_wr.en),
		.wr_addr(mem_wr.addr),
		.wr_data(mem_wr.data),
		.rd_en(rd_en),
		.rd_addr(addr_reg),
		.rd_data(rd_data)
	);

	// buffer between array and serialiser; a slow host stalls reads
	stream_fifo #(
		.WIDTH(DW),
		.DEPTH(eeprom_stream_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.in_valid(pend_reg),
		.in_ready(fifo_in_ready),
		.in_data(rd_data),
		.out_valid(fifo_out_valid),
		.out_ready(pop),
		.out_data(fifo_out_data)
	);

	assign sda_out = sda_out_reg;
	assign sda_oe = sda_oe_reg;
	assign sda_level = sda_lvl_reg;
	assign scl_level = scl_lvl_reg;
	assign bidir_mode = bidir_reg;
	assign write_permit = permit_reg;
endmodule
`default_nettype wire

/* File: eeprom_streamer_chk.sv */
// checker for the streamer top ports
// assumes one 100 MHz clock and the power-up reset rst_b
`timescale 1ns/1ps
`default_nettype none
module eeprom_streamer_chk (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic transmit_only_clock,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire eeprom_stream_pkg::mem_wr_t mem_wr,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic sda_level,
	input wire logic scl_level,
	input wire logic bidir_mode,
	input wire logic write_permit
);
	logic [5:0] low_reg, low_next;
	logic [3:0] rise_reg, rise_next, since_reg, since_next;
	logic seen_reg, seen_next, tclk_reg, tclk_next, rise;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// raw pin counters; saturate so long runs never wrap into a false hit
	always_comb begin
		rise = transmit_only_clock & ~tclk_reg;
		tclk_next = transmit_only_clock;
		seen_next = seen_reg | scl_in;
		low_next = scl_in ? 6'h0 : low_reg + 6'(low_reg != 6'h3f);
		rise_next = rise_reg + 4'(rise && rise_reg != 4'hf);
		since_next = rise ? 4'h0 : since_reg + 4'(since_reg != 4'hf);
	end
	// registers only
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{low_reg, rise_reg, since_reg} <= '0;
			{seen_reg, tclk_reg} <= '0;
		end else begin
			{low_reg, rise_reg, since_reg} <= {low_next, rise_next, since_next};
			{seen_reg, tclk_reg} <= {seen_next, tclk_next};
		end
	end
	a_bidir_sticky: assert property (bidir_mode |=> bidir_mode)
		else $error("bidir mode fell");
	a_bidir_quiet: assert property (bidir_mode |-> !sda_oe)
		else $error("line driven in bidir mode");
	a_permit_gate: assert property (!bidir_mode |-> !write_permit)
		else $error("write permit outside bidir");
	a_permit_follow: assert property (bidir_mode && $past(bidir_mode, 6) &&
		$past(transmit_only_clock, 2) == $past(transmit_only_clock, 6)
		|-> write_permit == $past(transmit_only_clock, 4))
		else $error("write permit not tracking clock pin");
	// every flop of the three-stage chain must have run out of reset
	a_sda_sync: assert property ($past(rst_b, 1) && $past(rst_b, 2) &&
		$past(rst_b, 3) && $past(sda_in, 1) == $past(sda_in, 5)
		|-> sda_level == $past(sda_in, 3))
		else $error("sda level not tracking line");
	a_scl_sync: assert property ($past(rst_b, 1) && $past(rst_b, 2) &&
		$past(rst_b, 3) && $past(scl_in, 1) == $past(scl_in, 5)
		|-> scl_level == $past(scl_in, 3))
		else $error("scl level not tracking pin");
	a_hold_time: assert property ($rose(bidir_mode) |->
		low_reg >= 6'h1e && low_reg <= 6'h2d)
		else $error("switch outside hold window");
	a_switch_bound: assert property (seen_reg && low_reg == 6'h30 |-> bidir_mode)
		else $error("no switch after long scl low");
	a_sync_release: assert property (rise_reg <= 4'h9 |-> !sda_oe)
		else $error("line driven during sync");
	a_bit_timing: assert property ($changed(sda_oe) && !$rose(bidir_mode)
		|-> since_reg >= 4'h2 && since_reg <= 4'h6)
		else $error("output change not after clock rise");
endmodule
bind eeprom_streamer eeprom_streamer_chk eeprom_streamer_chk_i (.clk(clk),
	.rst_b(rst_b), .transmit_only_clock(transmit_only_clock),
	.scl_in(scl_in), .sda_in(sda_in), .mem_wr(mem_wr), .sda_out(sda_out),
	.sda_oe(sda_oe), .sda_level(sda_level), .scl_level(scl_level),
	.bidir_mode(bidir_mode), .write_permit(write_permit));
`default_nettype wire

/* File: host_model.sv */
// host side: drives the streaming clock and scl, resolves sda
// assumes sda has a pull-up, so a released line reads high
`timescale 1ns/1ps
`default_nettype none
module host_model (
	output var logic transmit_only_clock,
	output var logic scl_in,
	output logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe
);
	// open-drain wire with pull-up
	assign sda_in = sda_oe ? sda_out : 1'b1;
	// clock stands low between frames; scl held high to stay streaming
	initial begin
		transmit_only_clock = 1'b0;
		scl_in = 1'b1;
	end
	// one 125 ns clock; sample late in the high phase
	// pins move by non-blocking assignment so no clk edge races them
	task automatic tick(output logic oe, output logic d);
		transmit_only_clock <= 1'b1;
		#60;
		oe = sda_oe;
		d = sda_in;
		#2.5;
		transmit_only_clock <= 1'b0;
		#62.5;
	endtask
	task automatic pins(input logic t, input logic s);
		transmit_only_clock <= t;
		scl_in <= s;
	endtask
	// short low glitch on scl, under the spike window
	task automatic spike();
		scl_in <= 1'b0;
		#30;
		scl_in <= 1'b1;
	endtask
endmodule
`default_nettype wire

/* File: tb_eeprom_streamer.sv */
// self-checking bench for the streamer with a host model
// assumes 100 MHz clk; array is loaded through mem_wr first
`timescale 1ns/1ps
`default_nettype none
module tb_eeprom_streamer;
	logic clk, rst_b, sda_out, sda_oe, sda_in, tclk, scl;
	logic sda_level, scl_level, bidir_mode, write_permit;
	eeprom_stream_pkg::mem_wr_t mem_wr;
	int n_errors = 0;
	int n_checks = 0;
	eeprom_streamer eeprom_streamer_i (.clk(clk), .rst_b(rst_b),
		.transmit_only_clock(tclk), .scl_in(scl), .sda_in(sda_in),
		.mem_wr(mem_wr), .sda_out(sda_out), .sda_oe(sda_oe),
		.sda_level(sda_level), .scl_level(scl_level),
		.bidir_mode(bidir_mode), .write_permit(write_permit));
	host_model host_model_i (.transmit_only_clock(tclk), .scl_in(scl),
		.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));
	always #5 clk = ~clk;
	// address is recoverable from each byte, so start address is free
	function automatic logic [7:0] pat(input int a);
		return {7'(a), 1'b0} ^ 8'ha5;
	endfunction
	task automatic check(input logic ok, input string msg);
		n_checks++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask
	task automatic summarize();
		if (n_errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// back-to-back writes of the whole array
	task automatic t_fill();
		for (int a = 0; a < 128; a++) begin
			@(posedge clk);
			mem_wr <= '{1'b1, 7'(a), pat(a)};
		end
		@(posedge clk);
		mem_wr <= '0;
	endtask
	task automatic t_sync();
		logic oe, d;
		for (int i = 0; i < 9; i++) begin
			host_model_i.tick(oe, d);
			check(oe === 1'b0 && bidir_mode === 1'b0, "sync drive");
		end
	endtask
	task automatic t_spike();
		host_model_i.spike();
		repeat (20) @(posedge clk);
		check(bidir_mode === 1'b0, "spike switched");
	endtask
	// first bytes may come from prefetch before the fill, so skip them
	task automatic t_stream();
		logic oe, d;
		logic [7:0] b;
		logic [6:0] a, prev;
		for (int n = 0; n < 148; n++) begin
			for (int i = 0; i < 8; i++) begin
				host_model_i.tick(oe, d);
				check(oe === 1'b1, "bit not driven");
				b = {b[6:0], d};
			end
			host_model_i.tick(oe, d);
			check(oe === 1'b0, "null slot driven");
			a = 7'((b ^ 8'ha5) >> 1);
			if (n > 18)
				check(b[0] === 1'b1 && a === prev + 7'h1, "byte order");
			prev = a;
		end
	endtask
	task automatic t_switch();
		logic oe, d;
		int c;
		c = 0;
		host_model_i.tick(oe, d);
		host_model_i.pins(1'b0, 1'b0);
		while (bidir_mode !== 1'b1 && c < 60) begin
			@(posedge clk);
			#1;
			c++;
			// the driven bit must neither drop nor change in the hold
			if (c < 30)
				check(sda_oe === 1'b1 && sda_in === d, "hold lost");
		end
		check(c >= 30 && c <= 45 && sda_oe === 1'b0, "switch time");
		host_model_i.tick(oe, d);
		check(oe === 1'b0, "bidir drives");
		host_model_i.pins(1'b1, 1'b1);
		repeat (8) @(posedge clk);
		#1;
		check(write_permit === 1'b1, "permit low");
		host_model_i.pins(1'b0, 1'b0);
		repeat (8) @(posedge clk);
		#1;
		check(write_permit === 1'b0 && bidir_mode === 1'b1, "mode lost");
		// scl back high so streaming after the reset keeps its mode
		host_model_i.pins(1'b0, 1'b1);
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		check(bidir_mode === 1'b0 && sda_oe === 1'b0, "reset mode");
	endtask
	// a mid-run reset must bring back sync, then byte-aligned streaming
	task automatic t_restart();
		logic oe, d;
		logic [7:0] b;
		t_sync();
		for (int i = 0; i < 8; i++) begin
			host_model_i.tick(oe, d);
			check(oe === 1'b1, "no stream after reset");
			b = {b[6:0], d};
		end
		check(b[0] === 1'b1, "restart not byte aligned");
	endtask
	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		mem_wr = '0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		t_fill();
		t_sync();
		t_spike();
		t_stream();
		t_switch();
		t_restart();
		summarize();
	end
	// stream runs about 170 us; allow margin
	initial begin
		#400_000;
		n_errors++;
		summarize();
	end
endmodule
`default_nettype wire
